// file: verilog/supply_monitor_pkg.sv
// constants and carrier types of the supply integrity and reset monitor
package supply_monitor_pkg;
   // --------------------------------------------------------------
   // clock and timing
   // --------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int RST_OUT_MIN_NS = 20000;
   localparam int RST_OUT_MIN_CYC = (RST_OUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DELAY_SHORT_CYC = 256;
   localparam int DELAY_LONG_CYC = 4096;
   localparam int DLY_W = 13;
   localparam int PW_W = 16;
   localparam logic [DLY_W-1:0] DELAY_SHORT_CNT = DLY_W'(DELAY_SHORT_CYC - 1);
   localparam logic [DLY_W-1:0] DELAY_LONG_CNT = DLY_W'(DELAY_LONG_CYC - 1);
   localparam logic [PW_W-1:0] RST_OUT_CNT = PW_W'(RST_OUT_MIN_CYC);

   // --------------------------------------------------------------
   // register map
   // --------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFS_CTRL_STATUS = 4'h0;
   localparam int BIT_EW_IE = 6;
   localparam int BIT_EW_FLAG = 5;
   localparam int BIT_LVD_RF = 4;
   localparam int BIT_LOCKED = 3;
   localparam int BIT_WDG_RF = 0;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0;

   // --------------------------------------------------------------
   // option and carrier types
   // --------------------------------------------------------------
   typedef enum logic [1:0] {
      LVL_LOW = 2'h0,
      LVL_MED = 2'h1,
      LVL_HIGH = 2'h2
   } lvd_level_t;

   localparam int NUM_LVL = 3;

   // one bit per threshold level, high while vdd is below that level
   typedef struct packed {
      logic [NUM_LVL-1:0] lvd_below_upper;
      logic [NUM_LVL-1:0] lvd_below_lower;
      logic [NUM_LVL-1:0] ew_below_upper;
      logic [NUM_LVL-1:0] ew_below_lower;
   } supply_cmp_t;

   typedef struct packed {
      logic lvd_enable;
      lvd_level_t lvd_level;
      logic long_delay;
   } option_t;

   typedef enum logic [2:0] {
      SEQ_RUN = 3'h1,
      SEQ_ACTIVE = 3'h2,
      SEQ_DELAY = 3'h4
   } seq_state_t;
endpackage

// file: verilog/supply_integrity_reset_monitor.sv
// supply integrity, reset source sequencing and control/status register
// Summary of operation
// - lvd reset drives shared reset pin low
// - watchdog underflow drives pin minimum pulse width
// - lvd reset with upper/lower threshold hysteresis
// - lvd option enable; disabled gives no reset
// - lvd threshold selected low, medium, high
// - early warning only when lvd enabled
// - below early-warning lower: set flag, request
// - above upper: flag clears, no interrupt
// - request on flag rise, enabled, unmasked
// - pending cleared on entering service routine
// - wait mode unchanged; interrupt wakes device
// - halt freezes register; no halt wakeup
// - lvd reset flag bit 4, software clears
// - lvd flag undefined when lvd disabled
// - pin and watchdog resets keep lvd flag
// - watchdog flag bit 0, cleared by lvd
// - flags encode last lvd or watchdog reset; pin reset leaves them unchanged
// - pll lock bit 3 hardware only
// - interrupt enable bit 6 read/write
// - early warning flag bit 5 read only
// - reset clears register except source flags
// - release delay 256 or 4096 cycles
`timescale 1ns/1ps
`default_nettype none
module supply_integrity_reset_monitor
   import supply_monitor_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic [ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [DATA_W-1:0] avs_writedata_in,
   output logic [DATA_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire supply_cmp_t supply_cmp_in,
   input wire option_t option_in,
   input wire logic wdg_underflow_in,
   input wire logic pll_locked_in,
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe_out,
   output logic cpu_reset_out,
   input wire logic cpu_irq_mask_in,
   input wire logic irq_ack_in,
   input wire logic wait_mode_in,
   input wire logic halt_mode_in,
   output logic irq_out,
   output logic wake_out
);

   // ---------------------------------------------------------------
   // comparator synchroniser
   // ---------------------------------------------------------------
   supply_cmp_t cmp_meta_ff;
   supply_cmp_t cmp_sync_ff;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         cmp_meta_ff <= '0;
         cmp_sync_ff <= '0;
      end else begin
         cmp_meta_ff <= supply_cmp_in;
         cmp_sync_ff <= cmp_meta_ff;
      end
   end

   function automatic logic pick(input logic [NUM_LVL-1:0] v, input lvd_level_t lvl);
      pick = v[lvl];
   endfunction

   logic lvd_below_upper;
   logic lvd_below_lower;
   logic ew_below_upper;
   logic ew_below_lower;
   assign lvd_below_upper = pick(cmp_sync_ff.lvd_below_upper, option_in.lvd_level);
   assign lvd_below_lower = pick(cmp_sync_ff.lvd_below_lower, option_in.lvd_level);
   assign ew_below_upper = pick(cmp_sync_ff.ew_below_upper, option_in.lvd_level);
   assign ew_below_lower = pick(cmp_sync_ff.ew_below_lower, option_in.lvd_level);

   // ---------------------------------------------------------------
   // low voltage detector with hysteresis
   // ---------------------------------------------------------------
   logic lvd_active_ff;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         lvd_active_ff <= 1'b0;
      end else if (!option_in.lvd_enable) begin
         lvd_active_ff <= 1'b0;
      end else if (lvd_active_ff) begin
         lvd_active_ff <= lvd_below_upper;
      end else begin
         lvd_active_ff <= lvd_below_lower;
      end
   end

   // ---------------------------------------------------------------
   // reset sequencer
   // ---------------------------------------------------------------
   seq_state_t state_ff;
   logic [DLY_W-1:0] delay_cnt_ff;
   logic [PW_W-1:0] wdg_pw_cnt_ff;
   logic ext_reset;
   logic wdg_event;
   logic any_source;

   // the pin reads back our own drive, so it only counts while released
   assign ext_reset = !reset_pin_in && !reset_pin_oe_out;
   assign wdg_event = wdg_underflow_in && (state_ff == SEQ_RUN);
   assign any_source = lvd_active_ff || ext_reset || (wdg_pw_cnt_ff != '0) || wdg_event;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         wdg_pw_cnt_ff <= '0;
      end else if (wdg_event) begin
         wdg_pw_cnt_ff <= RST_OUT_CNT;
      end else if (wdg_pw_cnt_ff != '0) begin
         wdg_pw_cnt_ff <= wdg_pw_cnt_ff - PW_W'(1);
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         state_ff <= SEQ_ACTIVE;
         delay_cnt_ff <= '0;
      end else begin
         unique case (state_ff)
            SEQ_RUN: begin
               if (any_source) begin
                  state_ff <= SEQ_ACTIVE;
               end
            end
            SEQ_ACTIVE: begin
               if (!any_source) begin
                  state_ff <= SEQ_DELAY;
                  delay_cnt_ff <= option_in.long_delay ? DELAY_LONG_CNT
                                                       : DELAY_SHORT_CNT;
               end
            end
            SEQ_DELAY: begin
               if (lvd_active_ff) begin
                  state_ff <= SEQ_ACTIVE;
               end else if (delay_cnt_ff == '0) begin
                  state_ff <= SEQ_RUN;
               end else begin
                  delay_cnt_ff <= delay_cnt_ff - DLY_W'(1);
               end
            end
         endcase
      end
   end

   logic nxt_pin_drive;
   // the pin also stays low through the delay phase, starting in the cycle that leaves
   // the active phase, so after an lvd or watchdog reset the line never shows a one-cycle gap between the two
   assign nxt_pin_drive = lvd_active_ff || (wdg_pw_cnt_ff != '0) || wdg_event
                          || (state_ff == SEQ_DELAY)
                          || (state_ff == SEQ_ACTIVE && !any_source);

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         reset_pin_oe_out <= 1'b0;
         reset_pin_out <= 1'b0;
         cpu_reset_out <= 1'b1;
      end else begin
         reset_pin_oe_out <= nxt_pin_drive;
         reset_pin_out <= 1'b0;
         cpu_reset_out <= !(state_ff == SEQ_RUN && !any_source);
      end
   end

   logic in_reset;
   assign in_reset = cpu_reset_out;

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   logic bus_req;
   logic csr_hit;
   logic csr_write;
   assign bus_req = avs_read_in || avs_write_in;
   assign csr_hit = avs_address_in == OFS_CTRL_STATUS;
   assign csr_write = avs_write_in && !avs_waitrequest_out && csr_hit;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         avs_waitrequest_out <= 1'b1;
      end else begin
         avs_waitrequest_out <= !(bus_req && avs_waitrequest_out);
      end
   end

   // ---------------------------------------------------------------
   // control/status register
   // ---------------------------------------------------------------
   logic ew_ie_ff;
   logic ew_flag_ff;
   logic lvd_rf_ff;
   logic locked_ff;
   logic wdg_rf_ff;
   logic [DATA_W-1:0] csr_value;

   always_comb begin
      csr_value = READ_ZERO;
      csr_value[BIT_EW_IE] = ew_ie_ff;
      csr_value[BIT_EW_FLAG] = ew_flag_ff;
      csr_value[BIT_LVD_RF] = lvd_rf_ff;
      csr_value[BIT_LOCKED] = locked_ff;
      csr_value[BIT_WDG_RF] = wdg_rf_ff;
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         avs_readdata_out <= '0;
      end else if (avs_read_in && avs_waitrequest_out) begin
         avs_readdata_out <= csr_hit ? csr_value : READ_ZERO;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in || in_reset) begin
         ew_ie_ff <= 1'b0;
      end else if (halt_mode_in) begin
         ew_ie_ff <= ew_ie_ff;
      end else if (csr_write) begin
         ew_ie_ff <= avs_writedata_in[BIT_EW_IE];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in || in_reset || !option_in.lvd_enable) begin
         ew_flag_ff <= 1'b0;
      end else if (halt_mode_in) begin
         ew_flag_ff <= ew_flag_ff;
      end else if (ew_below_lower) begin
         ew_flag_ff <= 1'b1;
      end else if (!ew_below_upper) begin
         ew_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in || in_reset) begin
         locked_ff <= 1'b0;
      end else if (!halt_mode_in) begin
         locked_ff <= pll_locked_in;
      end
   end

   // source flags survive the internal reset; only a hardware event sets them,
   // and a set in the same cycle as a software clear wins
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         lvd_rf_ff <= 1'b0;
      end else if (lvd_active_ff) begin
         // never set while the detector is off by option, so the bit then means nothing
         lvd_rf_ff <= 1'b1;
      end else if (csr_write && !halt_mode_in && !avs_writedata_in[BIT_LVD_RF]) begin
         lvd_rf_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         wdg_rf_ff <= 1'b0;
      end else if (wdg_event) begin
         wdg_rf_ff <= 1'b1;
      end else if (lvd_active_ff) begin
         wdg_rf_ff <= 1'b0;
      end else if (csr_write && !halt_mode_in && !avs_writedata_in[BIT_WDG_RF]) begin
         wdg_rf_ff <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // early warning interrupt
   // ---------------------------------------------------------------
   logic ew_flag_q_ff;
   logic ew_rise;
   logic nxt_pending;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         ew_flag_q_ff <= 1'b0;
      end else begin
         ew_flag_q_ff <= ew_flag_ff;
      end
   end

   assign ew_rise = ew_flag_ff && !ew_flag_q_ff;
   // a new rise in the acknowledge cycle stays pending
   assign nxt_pending = (in_reset || !option_in.lvd_enable) ? 1'b0
                      : (ew_rise && ew_ie_ff && !cpu_irq_mask_in) ? 1'b1
                      : irq_ack_in ? 1'b0
                      : irq_out;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         irq_out <= 1'b0;
         wake_out <= 1'b0;
      end else begin
         irq_out <= nxt_pending;
         // halt never wakes from here, the flag is frozen there anyway
         wake_out <= nxt_pending && wait_mode_in && !halt_mode_in;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   // checker counters: length of the current pin drive and of the current delay phase,
   // both saturating so that a stuck phase cannot wrap back into range
   logic [PW_W-1:0] pin_low_cnt_ff;
   logic [DLY_W-1:0] delay_len_ff;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in || !reset_pin_oe_out) begin
         pin_low_cnt_ff <= '0;
      end else if (pin_low_cnt_ff != '1) begin
         pin_low_cnt_ff <= pin_low_cnt_ff + PW_W'(1);
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in || state_ff != SEQ_DELAY) begin
         delay_len_ff <= '0;
      end else if (delay_len_ff != '1) begin
         delay_len_ff <= delay_len_ff + DLY_W'(1);
      end
   end

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);

   sequence s_lvd_starts;
      !lvd_active_ff ##1 lvd_active_ff;
   endsequence

   sequence s_wdg_fires;
      wdg_event ##1 1'b1;
   endsequence

   a_lvd_pin_drive: assert property (lvd_active_ff |=> reset_pin_oe_out)
      else $error("pin not driven during lvd reset");
   a_wdg_pulse_min: assert property (s_wdg_fires |-> reset_pin_oe_out [*8])
      else $error("watchdog reset pulse too short");
   a_lvd_hysteresis: assert property (lvd_active_ff && lvd_below_upper
      && option_in.lvd_enable && $stable(option_in) |=> lvd_active_ff)
      else $error("lvd released above lower threshold");
   a_lvd_disabled: assert property (!option_in.lvd_enable |=> !lvd_active_ff)
      else $error("lvd reset while disabled");
   a_ew_gated: assert property (!option_in.lvd_enable |=> !ew_flag_ff ##1 !irq_out)
      else $error("early warning active with lvd off");
   a_ew_set: assert property (ew_below_lower && option_in.lvd_enable && !halt_mode_in
      && !in_reset |=> ew_flag_ff)
      else $error("early warning flag not set");
   a_ew_clear_quiet: assert property ($fell(ew_flag_ff) && !irq_out |=> !irq_out)
      else $error("interrupt raised on recovery");
   a_irq_cause: assert property ($rose(irq_out) |-> $past(ew_rise)
      && $past(ew_ie_ff) && !$past(cpu_irq_mask_in))
      else $error("interrupt without enabled flag rise");
   a_irq_ack_clear: assert property (irq_out && irq_ack_in && !ew_rise |=> !irq_out)
      else $error("pending not cleared by service entry");
   a_halt_freeze: assert property (halt_mode_in && !in_reset && !lvd_active_ff
      && !$past(lvd_active_ff) |=> $stable(ew_flag_ff) && $stable(ew_ie_ff))
      else $error("register changed in halt");
   a_lvd_flag_set: assert property (s_lvd_starts |=> lvd_rf_ff && !wdg_rf_ff)
      else $error("lvd source flags wrong");
   a_delay_length: assert property ($rose(state_ff == SEQ_DELAY) && !lvd_active_ff
      |-> (state_ff == SEQ_DELAY) [*8])
      else $error("release delay too short");
   a_delay_count: assert property ($past(state_ff == SEQ_DELAY) && state_ff == SEQ_RUN
      |-> delay_len_ff - DLY_W'(1)
         == (option_in.long_delay ? DELAY_LONG_CNT : DELAY_SHORT_CNT))
      else $error("release delay length wrong");
   a_pin_pulse_len: assert property ($fell(reset_pin_oe_out)
      |-> pin_low_cnt_ff >= RST_OUT_CNT)
      else $error("reset pin pulse too short");

endmodule
`default_nettype wire

// file: sim/supply_far_side.sv
// model of the supply comparators and the wired reset line outside the monitor
`timescale 1ns/1ps
`default_nettype none
module supply_far_side
   import supply_monitor_pkg::*;
#(
   parameter int LO0 = 2000,
   parameter int STEP = 500,
   parameter int HYS = 100,
   parameter int EW = 300
)(
   input wire logic [15:0] vdd_mv_in,
   input wire logic ext_low_in,
   input wire logic pin_oe_in,
   input wire logic pin_drive_in,
   output var supply_cmp_t cmp_out,
   output logic pin_level_out
);
   // --------------------------------------------------------------
   // comparators
   // --------------------------------------------------------------
   // ideal comparators; choosing the upper or the lower one is left to the monitor
   always_comb begin
      for (int l = 0; l < NUM_LVL; l++) begin
         cmp_out.lvd_below_lower[l] = int'(vdd_mv_in) < LO0 + STEP * l;
         cmp_out.lvd_below_upper[l] = int'(vdd_mv_in) < LO0 + STEP * l + HYS;
         cmp_out.ew_below_lower[l] = int'(vdd_mv_in) < LO0 + STEP * l + EW;
         cmp_out.ew_below_upper[l] = int'(vdd_mv_in) < LO0 + STEP * l + EW + HYS;
      end
   end
   // --------------------------------------------------------------
   // reset line
   // --------------------------------------------------------------
   // pull-up: the line is low whenever either party pulls it
   assign pin_level_out = ~ext_low_in & ~(pin_oe_in & ~pin_drive_in);
endmodule
`default_nettype wire

// file: sim/supply_integrity_reset_monitor_tb.sv
// self-checking bench of the supply integrity and reset monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module supply_integrity_reset_monitor_tb;
   import supply_monitor_pkg::*;
   localparam int LO0 = 2000;
   localparam int STEP = 500;
   localparam logic [15:0] VOK = 16'h0fa0;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic [ADDR_W-1:0] addr = '0;
   logic rd = 1'b0, wr = 1'b0, wreq, wdg = 1'b0, pll = 1'b1, pin_lvl, pin_o, oe, cpu_rst;
   logic mask = 1'b0, ack = 1'b0, waitm = 1'b0, haltm = 1'b0, irq, wake, ext_low = 1'b0;
   logic [DATA_W-1:0] wdata = '0, rdata, q;
   logic [15:0] vdd = VOK;
   supply_cmp_t cmp;
   option_t opt = '{lvd_enable: 1'b1, lvd_level: LVL_LOW, long_delay: 1'b0};
   int errors = 0;
   int checks = 0;
   int n;

   supply_integrity_reset_monitor i_supply_integrity_reset_monitor (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_address_in(addr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wreq), .supply_cmp_in(cmp), .option_in(opt),
      .wdg_underflow_in(wdg), .pll_locked_in(pll), .reset_pin_in(pin_lvl),
      .reset_pin_out(pin_o), .reset_pin_oe_out(oe), .cpu_reset_out(cpu_rst),
      .cpu_irq_mask_in(mask), .irq_ack_in(ack), .wait_mode_in(waitm), .halt_mode_in(haltm),
      .irq_out(irq), .wake_out(wake));
   supply_far_side #(.LO0(LO0), .STEP(STEP)) i_supply_far_side (.vdd_mv_in(vdd),
      .ext_low_in(ext_low), .pin_oe_in(oe), .pin_drive_in(pin_o), .cmp_out(cmp),
      .pin_level_out(pin_lvl));

   initial forever #50 clk_sys_in = ~clk_sys_in;

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   function automatic logic [15:0] lo(int l);
      return 16'(LO0 + STEP * l);
   endfunction
   task automatic tick(int m);
      repeat (m) @(posedge clk_sys_in);
   endtask
   task automatic finish_test;
      if (errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // request held until waitrequest is sampled low at a rising edge, released after it
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_sys_in);
      addr <= a;
      wdata <= d;
      rd <= ~w;
      wr <= w;
      do begin
         @(posedge clk_sys_in);
      end while (wreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex, string nm);
      bus(1'b0, a, '0);
      `CHK(nm, ex, q)
   endtask
   // counts cycles until the pin drive (sel=1) or the internal reset (sel=0) drops
   task automatic wait_low(input logic sel, output int k);
      k = 0;
      do begin
         @(negedge clk_sys_in);
         k++;
      end while ((sel ? oe : cpu_rst) !== 1'b0 && k < 6000);
      if (k >= 6000) begin
         errors++;
         finish_test();
      end
      tick(1);
   endtask
   task automatic wdg_reset;
      wdg <= 1'b1;
      tick(1);
      wdg <= 1'b0;
      tick(2);
      `CHK("wdg_oe", 1'b1, oe)
      `CHK("wdg_pin_level", 1'b0, pin_lvl)
      `CHK("wdg_pin_drive", 1'b0, pin_o)
      wait_low(1'b1, n);
      `CHK("wdg_pulse", 1'b1, n >= RST_OUT_MIN_CYC)
      wait_low(1'b0, n);
   endtask
   task automatic ext_reset;
      ext_low <= 1'b1;
      tick(4);
      `CHK("ext_cpu_rst", 1'b1, cpu_rst)
      ext_low <= 1'b0;
      wait_low(1'b0, n);
   endtask

   // --------------------------------------------------------------
   // sequence
   // --------------------------------------------------------------
   initial begin
      #2000000;
      errors++;
      finish_test();
   end

   initial begin
      tick(16);
      rst_in <= 1'b0;
      wait_low(1'b0, n);
      rdchk(OFS_CTRL_STATUS, 32'h08, "csr_reset");
      bus(1'b1, OFS_CTRL_STATUS, 32'h40);
      rdchk(OFS_CTRL_STATUS, 32'h48, "ie_set");
      bus(1'b1, 4'h4, 32'h00);
      rdchk(4'h4, 32'h00, "unmapped");
      rdchk(OFS_CTRL_STATUS, 32'h48, "unmapped_write");
      pll <= 1'b0;
      tick(4);
      rdchk(OFS_CTRL_STATUS, 32'h40, "unlocked");
      pll <= 1'b1;
      waitm <= 1'b1;
      vdd <= lo(0) + 16'h00c8;
      tick(6);
      `CHK("ew_irq", 1'b1, irq)
      `CHK("ew_wake", 1'b1, wake)
      ack <= 1'b1;
      tick(1);
      ack <= 1'b0;
      tick(2);
      `CHK("ack_clr", 1'b0, irq)
      bus(1'b1, OFS_CTRL_STATUS, 32'h40);
      rdchk(OFS_CTRL_STATUS, 32'h68, "ew_flag_ro");
      vdd <= lo(0) + 16'h015e;
      tick(6);
      rdchk(OFS_CTRL_STATUS, 32'h68, "ew_hyst");
      vdd <= VOK;
      waitm <= 1'b0;
      tick(6);
      rdchk(OFS_CTRL_STATUS, 32'h48, "ew_recover");
      `CHK("no_irq_rise", 1'b0, irq)
      mask <= 1'b1;
      vdd <= lo(0) + 16'h00c8;
      tick(6);
      `CHK("masked", 1'b0, irq)
      vdd <= VOK;
      tick(6);
      mask <= 1'b0;
      haltm <= 1'b1;
      tick(2);
      pll <= 1'b0;
      vdd <= lo(0) + 16'h00c8;
      tick(6);
      rdchk(OFS_CTRL_STATUS, 32'h48, "halt_frozen");
      `CHK("halt_no_wake", 1'b0, wake)
      pll <= 1'b1;
      vdd <= VOK;
      tick(6);
      haltm <= 1'b0;
      wdg_reset();
      rdchk(OFS_CTRL_STATUS, 32'h09, "wdg_src");
      for (int l = 0; l < NUM_LVL; l++) begin
         opt.lvd_level <= lvd_level_t'(l);
         vdd <= lo(l) + 16'h0096;
         tick(8);
         `CHK("above_lvl", 1'b0, oe)
         vdd <= lo(l) - 16'h0032;
         tick(8);
         `CHK("below_lvl", 1'b1, oe)
         vdd <= lo(l) + 16'h0032;
         tick(20);
         `CHK("lvd_hyst", 1'b1, oe)
         vdd <= VOK;
         wait_low(1'b0, n);
         `CHK("short_dly", 1'b1, n inside {[DELAY_SHORT_CYC:DELAY_SHORT_CYC + 12]})
      end
      rdchk(OFS_CTRL_STATUS, 32'h18, "lvd_src");
      opt.lvd_level <= LVL_LOW;
      opt.long_delay <= 1'b1;
      vdd <= lo(0) - 16'h0032;
      tick(8);
      vdd <= VOK;
      wait_low(1'b0, n);
      `CHK("long_dly", 1'b1, n inside {[DELAY_LONG_CYC:DELAY_LONG_CYC + 12]})
      opt.long_delay <= 1'b0;
      wdg_reset();
      rdchk(OFS_CTRL_STATUS, 32'h19, "wdg_keeps_lvd");
      ext_reset();
      rdchk(OFS_CTRL_STATUS, 32'h19, "ext_keeps_lvd");
      bus(1'b1, OFS_CTRL_STATUS, 32'h00);
      rdchk(OFS_CTRL_STATUS, 32'h08, "sw_clear");
      ext_reset();
      rdchk(OFS_CTRL_STATUS, 32'h08, "ext_src");
      opt.lvd_enable <= 1'b0;
      bus(1'b1, OFS_CTRL_STATUS, 32'h40);
      vdd <= lo(0) - 16'h0032;
      tick(10);
      `CHK("lvd_off", 1'b0, oe)
      `CHK("ew_off_irq", 1'b0, irq)
      bus(1'b0, OFS_CTRL_STATUS, '0);
      `CHK("ew_off_flag", 32'h48, q & 32'hffffffef)
      finish_test();
   end
endmodule
`default_nettype wire
